// ==== rtl/hvd_defs.vh ====
`ifndef HVD_DEFS_VH
`define HVD_DEFS_VH
`define HVD_ADDR_W 4
`define HVD_IMPL_W 4
`define HVD_DATA_W 8
`define HVD_BIT_CLR 1'b0
`define HVD_ADDR_CTRL 4'h0
`define HVD_ADDR_PSRC 4'h1
`define HVD_BIT_LVL 0
`define HVD_BIT_SRC 1
`define HVD_BIT_OE 2
`define HVD_BIT_PEN 3
`define HVD_BIT_P_OC 0
`define HVD_BIT_P_INT 1
`define HVD_BIT_P_IN2 2
`define HVD_BIT_P_IN3 3
`define HVD_REG_RST 4'h0
`define HVD_RD_ZERO 8'h00
`define HVD_HI_ZERO 4'h0
`endif

// ==== rtl/hvd_gate_drive.v ====
`timescale 1ns/1ps

`include "hvd_defs.vh"

module hvd_gate_drive (
    // Clock and reset.
    input wire mclk_in,
    input wire rst_b_in,
    // Register port.
    input wire [`HVD_ADDR_W-1:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    // Drive sources and protection inputs.
    input wire timer_drive_output_in,
    input wire overcurrent_status_in,
    input wire external_interrupt_input_in,
    input wire protection_input_two_in,
    input wire protection_input_three_in,
    // Drive pin.
    output reg drive_pin_out,
    output reg drive_pin_oe_out
);

// Register storage.
reg [`HVD_IMPL_W-1:0] drive_control;

reg [`HVD_IMPL_W-1:0] protection_source_enable;

// Protection trigger history.
reg trig_q;

// Pin path state and next values.
reg data_hold;

reg next_data_hold;

reg next_drive_pin_out;

reg next_drive_pin_oe_out;

// Read path next value.
reg [`HVD_DATA_W-1:0] next_rdata_out;

// Selected data level.
reg sel_data;

// Next register values.
wire [`HVD_IMPL_W-1:0] next_drive_control;

wire [`HVD_IMPL_W-1:0] next_protection_source_enable;

wire next_trig_q;

// Address hits.
wire ctrl_hit;

wire psrc_hit;

// Decoded strobes.
wire ctrl_wr;

wire psrc_wr;

wire ctrl_rd;

wire psrc_rd;

// Implemented write data.
wire [`HVD_IMPL_W-1:0] ctrl_wdata;

wire [`HVD_IMPL_W-1:0] psrc_wdata;

// Protection sources and trigger.
wire [`HVD_IMPL_W-1:0] src_vec;

wire [`HVD_IMPL_W-1:0] src_masked;

wire [`HVD_IMPL_W-1:0] ctrl_clr_mask;

wire trig;

wire trig_rise;

wire prot_clear;

// Control fields.
wire lvl_bit;

wire src_bit;

wire oe_bit;

wire pen_bit;

// Read words, upper bits included.
wire [`HVD_DATA_W-1:0] ctrl_rd_word;

wire [`HVD_DATA_W-1:0] psrc_rd_word;

// Loop index for the per-bit logic.
genvar gi;

// Address decode.
assign ctrl_hit = (addr_in == `HVD_ADDR_CTRL);

assign psrc_hit = (addr_in == `HVD_ADDR_PSRC);

// Write strobes per register.
assign ctrl_wr = wr_in && ctrl_hit;

assign psrc_wr = wr_in && psrc_hit;

// Read strobes per register.
assign ctrl_rd = rd_in && ctrl_hit;

assign psrc_rd = rd_in && psrc_hit;

// Only the implemented low bits of the write data are kept.
assign ctrl_wdata = wdata_in[`HVD_IMPL_W-1:0];

assign psrc_wdata = wdata_in[`HVD_IMPL_W-1:0];

// Control fields.
assign lvl_bit = drive_control[`HVD_BIT_LVL];

assign src_bit = drive_control[`HVD_BIT_SRC];

assign oe_bit = drive_control[`HVD_BIT_OE];

assign pen_bit = drive_control[`HVD_BIT_PEN];

// Protection sources in the order of their enable bits.
assign src_vec[`HVD_BIT_P_OC] = overcurrent_status_in;

assign src_vec[`HVD_BIT_P_INT] = external_interrupt_input_in;

assign src_vec[`HVD_BIT_P_IN2] = protection_input_two_in;

assign src_vec[`HVD_BIT_P_IN3] = protection_input_three_in;

// Each source passes only while its enable bit is set.
generate
    for (gi = 0; gi < `HVD_IMPL_W; gi = gi + 1) begin : g_src
        assign src_masked[gi] = src_vec[gi] &&
                                protection_source_enable[gi];
    end
endgenerate

// Trigger and its rising edge.
assign trig = |src_masked;

assign trig_rise = trig && !trig_q;

// History input for the edge detector.
assign next_trig_q = trig;

// The clear acts only while protection is enabled.
assign prot_clear = pen_bit && trig_rise;

// Clear mask covers the level and source select bits only.
generate
    for (gi = 0; gi < `HVD_IMPL_W; gi = gi + 1) begin : g_clr
        if ((gi == `HVD_BIT_LVL) || (gi == `HVD_BIT_SRC)) begin : g_hit
            assign ctrl_clr_mask[gi] = prot_clear;
        end else begin : g_keep
            assign ctrl_clr_mask[gi] = `HVD_BIT_CLR;
        end
    end
endgenerate

// Next control value: a hardware clear beats a same-cycle write.
generate
    for (gi = 0; gi < `HVD_IMPL_W; gi = gi + 1) begin : g_ctrl
        reg next_bit;

        always @* begin
            if (ctrl_clr_mask[gi]) begin
                next_bit = `HVD_BIT_CLR;
            end else if (ctrl_wr) begin
                next_bit = ctrl_wdata[gi];
            end else begin
                next_bit = drive_control[gi];
            end
        end

        assign next_drive_control[gi] = next_bit;
    end
endgenerate

// Next protection source enable value.
generate
    for (gi = 0; gi < `HVD_IMPL_W; gi = gi + 1) begin : g_psrc
        reg next_bit;

        always @* begin
            if (psrc_wr) begin
                next_bit = psrc_wdata[gi];
            end else begin
                next_bit = protection_source_enable[gi];
            end
        end

        assign next_protection_source_enable[gi] = next_bit;
    end
endgenerate

// Read words: unimplemented upper bits read as zero.
generate
    for (gi = 0; gi < `HVD_DATA_W; gi = gi + 1) begin : g_rdw
        if (gi < `HVD_IMPL_W) begin : g_impl
            assign ctrl_rd_word[gi] = drive_control[gi];

            assign psrc_rd_word[gi] = protection_source_enable[gi];
        end else begin : g_zero
            assign ctrl_rd_word[gi] = `HVD_BIT_CLR;

            assign psrc_rd_word[gi] = `HVD_BIT_CLR;
        end
    end
endgenerate

// Selected data level.
always @* begin
    if (src_bit) begin
        sel_data = timer_drive_output_in;
    end else begin
        sel_data = lvl_bit;
    end
end

// Data hold flag follows a control write by one cycle.
always @* begin
    next_data_hold = ctrl_wr;
end

// Pin enable follows the control register one cycle later.
always @* begin
    next_drive_pin_oe_out = oe_bit;
end

// Pin data waits one cycle after a control write.
always @* begin
    if (data_hold) begin
        next_drive_pin_out = drive_pin_out;
    end else begin
        next_drive_pin_out = sel_data;
    end
end

// Read data for the cycle after the strobe.
always @* begin
    next_rdata_out = `HVD_RD_ZERO;
    if (ctrl_rd) begin
        next_rdata_out = ctrl_rd_word;
    end else if (psrc_rd) begin
        next_rdata_out = psrc_rd_word;
    end else begin
        next_rdata_out = `HVD_RD_ZERO;
    end
end

// Drive control register.
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        drive_control <= `HVD_REG_RST;
    end else begin
        drive_control <= next_drive_control;
    end
end

// Protection source enable register.
// Enable bits take effect on the clock after they are written.
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        protection_source_enable <= `HVD_REG_RST;
    end else begin
        protection_source_enable <= next_protection_source_enable;
    end
end

// Trigger history runs even while protection is disabled.
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        trig_q <= `HVD_BIT_CLR;
    end else begin
        trig_q <= next_trig_q;
    end
end

// Data hold flag register.
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        data_hold <= `HVD_BIT_CLR;
    end else begin
        data_hold <= next_data_hold;
    end
end

// Pin output enable register.
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        drive_pin_oe_out <= `HVD_BIT_CLR;
    end else begin
        drive_pin_oe_out <= next_drive_pin_oe_out;
    end
end

// Pin data register.
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        drive_pin_out <= `HVD_BIT_CLR;
    end else begin
        drive_pin_out <= next_drive_pin_out;
    end
end

// Read data register.
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        rdata_out <= `HVD_RD_ZERO;
    end else begin
        rdata_out <= next_rdata_out;
    end
end

endmodule

// ==== sim/hvd_chk_assertions.sv ====
`timescale 1ns/1ps
module hvd_chk(
    input wire mclk_in, input wire rst_b_in, input wire [3:0] addr_in,
    input wire [7:0] wdata_in, input wire wr_in, input wire rd_in,
    input wire [7:0] rdata_out, input wire timer_drive_output_in,
    input wire drive_pin_out, input wire drive_pin_oe_out);
    wire wc = wr_in && addr_in == 4'h0;
    wire oe_w = wdata_in[2];
    wire [3:0] wl = wdata_in[3:0];
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    a_rd_hi: assert property (rd_in |=> rdata_out[7:4] == 4'h0)
        else $error("upper bits");
    a_rd_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("idle data");
    a_oe_lag: assert property (wc |-> ##2 drive_pin_oe_out == $past(oe_w, 2))
        else $error("enable");
    a_pin_hold: assert property (wc |-> ##2 $stable(drive_pin_out))
        else $error("data lag");
    a_lvl_pin: assert property (wc && wl == 4'h5 ##1 !wr_in |-> ##2 drive_pin_out)
        else $error("level");
    a_tmr_src: assert property (wc && wl == 4'h6 ##1 !wr_in
        |-> ##2 drive_pin_out == $past(timer_drive_output_in)) else $error("timer");
    a_src_rd: assert property (wr_in && addr_in == 4'h1 ##1 rd_in &&
        addr_in == 4'h1 && !wr_in |=> rdata_out[3:0] == $past(wl, 2)) else $error("source");
    a_unmapped: assert property (rd_in && addr_in > 4'h1 |=> rdata_out == 8'h00)
        else $error("unmapped");
    cover property (wc ##3 drive_pin_out);
    cover property (rd_in ##1 rdata_out != 8'h00);
    cover property ($fell(drive_pin_out) && drive_pin_oe_out);
endmodule
bind hvd_gate_drive hvd_chk u_chk(.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .timer_drive_output_in(timer_drive_output_in),
    .drive_pin_out(drive_pin_out), .drive_pin_oe_out(drive_pin_oe_out));

// ==== sim/hvd_gate_model.sv ====
`timescale 1ns/1ps
module hvd_gate_model(input wire pin_in, input wire oe_in, output wire gate_out);
    // The gate resistor pulls the MOS gate low while the pin floats.
    assign gate_out = oe_in ? pin_in : 1'b0;
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    reg mclk_in = 0, rst_b_in = 0, wr_in = 0, rd_in = 0;
    reg timer_drive_output_in = 0;
    reg [3:0] addr_in = 4'h0, s = 4'h0;
    reg [7:0] wdata_in = 8'h00;
    wire [7:0] rdata_out;
    wire drive_pin_out, drive_pin_oe_out, gate;
    wire overcurrent_status_in = s[0], external_interrupt_input_in = s[1];
    wire protection_input_two_in = s[2], protection_input_three_in = s[3];
    wire [7:0] pv = {6'h00, drive_pin_oe_out, gate};
    integer err_total = 0, num_checks = 0, i;
    hvd_gate_drive i_dut(.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out),
        .timer_drive_output_in(timer_drive_output_in),
        .overcurrent_status_in(overcurrent_status_in),
        .external_interrupt_input_in(external_interrupt_input_in),
        .protection_input_two_in(protection_input_two_in),
        .protection_input_three_in(protection_input_three_in),
        .drive_pin_out(drive_pin_out), .drive_pin_oe_out(drive_pin_oe_out));
    hvd_gate_model i_gate(.pin_in(drive_pin_out), .oe_in(drive_pin_oe_out),
        .gate_out(gate));
    initial forever #25 mclk_in = ~mclk_in;
    task cyc; begin @(posedge mclk_in); #1; end endtask
    task chk(input [39:0] n, input [7:0] e, input [7:0] v); begin
        num_checks = num_checks + 1;
        if (v !== e) begin
            err_total = err_total + 1;
            $display("mismatch %0s exp %h got %h", n, e, v);
        end
    end endtask
    task wr(input [3:0] ad, input [7:0] v); begin
        addr_in <= ad; wdata_in <= v; wr_in <= 1'b1; cyc; wr_in <= 1'b0;
    end endtask
    task rchk(input [3:0] ad, input [7:0] e); begin
        addr_in <= ad; rd_in <= 1'b1; cyc; rd_in <= 1'b0;
        chk("rdata", e, rdata_out);
    end endtask
    task conclude; begin
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    end endtask
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_b_in <= 1'b1; cyc;
        rchk(4'h0, 8'h00);
        wr(4'h1, 8'hFF); rchk(4'h1, 8'h0F);
        rchk(4'h5, 8'h00);
        $display("register test done");
        wr(4'h0, 8'hF5); chk("pin", 8'h00, pv); cyc; chk("pin", 8'h02, pv);
        cyc; chk("pin", 8'h03, pv);
        wr(4'h0, 8'h06); cyc; cyc;
        for (i = 1; i >= 0; i = i - 1) begin
            timer_drive_output_in <= i[0]; cyc; chk("pin", 8'h02 + i[7:0], pv);
        end
        wr(4'h0, 8'h01); cyc; cyc; chk("pin", 8'h00, pv);
        $display("pin test done");
        wr(4'h1, 8'h01); wr(4'h0, 8'h05); s <= 4'h1; cyc; cyc; rchk(4'h0, 8'h05);
        wr(4'h0, 8'h0F); s <= 4'hE; cyc; rchk(4'h0, 8'h0F);
        for (i = 0; i < 4; i = i + 1) begin
            wr(4'h1, 8'h01 << i); wr(4'h0, 8'h0D);
            s <= 4'h1 << i; cyc; rchk(4'h0, 8'h0C); chk("pin", 8'h02, pv);
            s <= 4'h0;
        end
        $display("protection test done");
        conclude;
    end
endmodule
